// File: design/bcal_pkg.sv
package bcal_pkg;

	// Register byte offsets on the APB window
	localparam logic [7:0] OFS_SYS = 8'h00;
	localparam logic [7:0] OFS_MOD_CTL = 8'h04;
	localparam logic [7:0] OFS_OVW = 8'h08;
	localparam logic [7:0] OFS_MOD_CNT = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_MASK = 8'h14;
	localparam logic [7:0] OFS_TIMER = 8'h18;
	localparam logic [7:0] OFS_CAP = 8'h20;
	localparam logic [7:0] OFS_HOLD = 8'h30;
	localparam logic [7:0] OFS_ACC = 8'h40;
	localparam logic [7:0] OFS_ACC_HOLD = 8'h50;

	// Fields of capture_system_control
	localparam int SYS_LATCH_QUEUE_SELECT = 0;
	localparam int SYS_BUFFER_ENABLE_BIT = 1;
	localparam int SYS_SAT = 2;
	localparam int SYS_CASC = 3;
	localparam int SYS_EDGE = 8;
	localparam logic [15:0] SYS_WMASK = 16'hFF1F;
	localparam logic [15:0] SYS_RST = 16'h0000;

	// Fields of modulus_control_reg
	localparam int MOD_EN = 0;
	localparam int MOD_PERIODIC = 1;
	localparam int MOD_FORCE = 2;
	localparam int MOD_TEN = 3;
	localparam logic [3:0] MOD_WMASK = 4'hB;
	localparam logic [3:0] MOD_CTL_RST = 4'h0;
	localparam logic [15:0] MOD_CNT_RST = 16'hFFFF;

	// Status, mask and interrupt bit positions
	localparam int ST_CH = 0;
	localparam int ST_MOD = 8;
	localparam int ST_PBOV = 9;
	localparam int ST_PAIN = 10;
	localparam int ST_PAOV = 11;
	localparam int ST_TOV = 12;
	localparam int NUM_IRQ = 13;

	// Per-channel control bundle
	typedef struct packed {
		logic latch_mode;
		logic no_overwrite_bit;
		logic latch_evt;
		logic cap_rd;
		logic hold_rd;
	} bcal_chan_ctl_type;

	// Per-accumulator control bundle
	typedef struct packed {
		logic inc;
		logic sat;
		logic latch_evt;
	} bcal_acc_ctl_type;

endpackage : bcal_pkg

// File: design/bcal_chan.sv
`timescale 1ns/1ps
`default_nettype none

module bcal_chan #(
	parameter int W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic edge_evt,
	input wire logic [W-1:0] timer,
	input wire bcal_pkg::bcal_chan_ctl_type ctl,
	output logic [W-1:0] cap_reg,
	output logic [W-1:0] hold_reg,
	output logic cap_full_reg,
	output logic hold_full_reg,
	output logic captured
);

	logic cap_we;
	logic hold_we;
	logic hold_src_cap;

	// Latch mode: edge writes capture, latch event moves it to holding
	// Queue mode: edge pushes capture into holding, then captures
	assign hold_src_cap = ctl.latch_mode ? ctl.latch_evt : edge_evt;
	assign hold_we = hold_src_cap & (!ctl.no_overwrite_bit | !hold_full_reg);
	assign cap_we = edge_evt & (!ctl.no_overwrite_bit | !cap_full_reg
		| (!ctl.latch_mode & hold_we));
	assign captured = cap_we;

	// Data registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_reg <= '0;
			hold_reg <= '0;
		end else begin
			if (hold_we)
				hold_reg <= cap_reg;
			if (cap_we)
				cap_reg <= timer;
		end
	end

	// Empty tracking: read or latch empties, a new write wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_full_reg <= 1'b0;
			hold_full_reg <= 1'b0;
		end else begin
			if (cap_we)
				cap_full_reg <= 1'b1;
			else if (ctl.cap_rd || (hold_we && ctl.latch_mode))
				cap_full_reg <= 1'b0;
			if (hold_we)
				hold_full_reg <= 1'b1;
			else if (ctl.hold_rd)
				hold_full_reg <= 1'b0;
		end
	end

endmodule : bcal_chan

`default_nettype wire

// File: design/bcal_acc.sv
`timescale 1ns/1ps
`default_nettype none

module bcal_acc #(
	parameter int W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire bcal_pkg::bcal_acc_ctl_type ctl,
	output logic [W-1:0] cnt_reg,
	output logic [W-1:0] hold_reg,
	output logic ovf
);

	logic at_max;
	logic [W-1:0] cnt_inc;

	// Overflow marks an edge arriving at full scale, saturated or not
	assign at_max = &cnt_reg;
	assign ovf = ctl.inc & at_max;
	assign cnt_inc = (at_max && ctl.sat) ? cnt_reg : cnt_reg + 1'b1;

	// Count, copy to holding and clear; an edge in the latch cycle counts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
			hold_reg <= '0;
		end else if (ctl.latch_evt) begin
			hold_reg <= cnt_reg;
			cnt_reg <= {{(W-1){1'b0}}, ctl.inc};
		end else if (ctl.inc) begin
			cnt_reg <= cnt_inc;
		end
	end

endmodule : bcal_acc

`default_nettype wire

// File: design/bcal_top.sv
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module bcal_top #(
	parameter int TICK_DIV = 1,
	parameter int NCH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NCH-1:0] cap_in,
	input wire logic [3:0] ext_ch_evt,
	output logic [7:0] irq_ch,
	output logic irq_mod,
	output logic irq_pbov,
	output logic irq_pain,
	output logic irq_paov,
	output logic irq_tov,
	output logic irq_any
);

	localparam int NI = bcal_pkg::NUM_IRQ;

	// Address block match, used by every indexed register group
	function automatic logic in_blk(input logic [7:0] a, input logic [7:0] base);
		in_blk = (a[7:4] == base[7:4]);
	endfunction : in_blk

	logic [15:0] sys_reg;
	logic [3:0] mod_ctl_reg;
	logic [NCH-1:0] ovw_reg;
	logic [15:0] mod_cnt_reg;
	logic [15:0] mod_load_reg;
	logic once_done_reg;
	logic [NI-1:0] status_reg;
	logic [NI-1:0] status_next;
	logic [NI-1:0] mask_reg;
	logic [NI-1:0] irq_reg;
	logic [15:0] timer_reg;
	logic [NCH-1:0] cap_prev_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [15:0] div_reg;

	// Bus phase decode
	wire acc_ph = psel & penable;
	wire xfer = acc_ph & pready_reg;
	wire wr = xfer & pwrite;
	wire rd = xfer & ~pwrite;
	wire [1:0] idx = paddr[3:2];

	// Register selects
	wire sel_sys = (paddr == bcal_pkg::OFS_SYS);
	wire sel_mod_ctl = (paddr == bcal_pkg::OFS_MOD_CTL);
	wire sel_ovw = (paddr == bcal_pkg::OFS_OVW);
	wire sel_mod_cnt = (paddr == bcal_pkg::OFS_MOD_CNT);
	wire sel_status = (paddr == bcal_pkg::OFS_STATUS);
	wire sel_mask = (paddr == bcal_pkg::OFS_MASK);
	wire sel_timer = (paddr == bcal_pkg::OFS_TIMER);
	wire sel_cap = in_blk(paddr, bcal_pkg::OFS_CAP);
	wire sel_hold = in_blk(paddr, bcal_pkg::OFS_HOLD);
	wire sel_acc = in_blk(paddr, bcal_pkg::OFS_ACC);
	wire sel_acc_hold = in_blk(paddr, bcal_pkg::OFS_ACC_HOLD);
	wire mapped = sel_sys | sel_mod_ctl | sel_ovw | sel_mod_cnt | sel_status
		| sel_mask | sel_timer | sel_cap | sel_hold | sel_acc | sel_acc_hold;

	// Control fields
	wire latch_mode = sys_reg[bcal_pkg::SYS_LATCH_QUEUE_SELECT];
	wire buf_en = sys_reg[bcal_pkg::SYS_BUFFER_ENABLE_BIT];
	wire sat_en = sys_reg[bcal_pkg::SYS_SAT];
	wire [1:0] casc = sys_reg[bcal_pkg::SYS_CASC +: 2];
	wire mod_en = mod_ctl_reg[bcal_pkg::MOD_EN];
	wire periodic = mod_ctl_reg[bcal_pkg::MOD_PERIODIC];
	wire timer_en = mod_ctl_reg[bcal_pkg::MOD_TEN];

	// Prescale divider: one-cycle tick for timer and modulus counter
	wire tick = (div_reg == 16'(TICK_DIV - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			div_reg <= 16'h0000;
		else
			div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
	end

	// Main timer, free running while enabled
	wire timer_ovf = tick & timer_en & (&timer_reg);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			timer_reg <= 16'h0000;
		else if (tick && timer_en)
			timer_reg <= timer_reg + 16'h0001;
	end

	// Modulus counter events
	wire mod_wr = wr & sel_mod_cnt;
	wire mod_wr_zero = mod_wr & (pwdata[15:0] == 16'h0000);
	wire mod_zero_hit = ~mod_wr & mod_en & tick & (mod_cnt_reg == 16'h0001);
	wire force_wr = wr & sel_mod_ctl & pwdata[bcal_pkg::MOD_FORCE];
	wire mod_latch = mod_zero_hit & (periodic | ~once_done_reg);
	wire latch_evt = latch_mode & buf_en
		& (mod_latch | mod_wr_zero | force_wr);

	// Modulus down-counter: reloads in periodic mode, parks at zero otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mod_cnt_reg <= bcal_pkg::MOD_CNT_RST;
			mod_load_reg <= bcal_pkg::MOD_CNT_RST;
		end else if (mod_wr) begin
			mod_cnt_reg <= pwdata[15:0];
			mod_load_reg <= pwdata[15:0];
		end else if (mod_zero_hit) begin
			mod_cnt_reg <= periodic ? mod_load_reg : 16'h0000;
		end else if (mod_en && tick && mod_cnt_reg != 16'h0000) begin
			mod_cnt_reg <= mod_cnt_reg - 16'h0001;
		end
	end

	// One-shot latching: armed by a count write, spent on first zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			once_done_reg <= 1'b0;
		else if (mod_wr)
			once_done_reg <= 1'b0;
		else if (mod_zero_hit)
			once_done_reg <= 1'b1;
	end

	// Control register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_reg <= bcal_pkg::SYS_RST;
			mod_ctl_reg <= bcal_pkg::MOD_CTL_RST;
			ovw_reg <= '0;
			mask_reg <= '0;
		end else if (wr) begin
			if (sel_sys)
				sys_reg <= pwdata[15:0] & bcal_pkg::SYS_WMASK;
			if (sel_mod_ctl)
				mod_ctl_reg <= pwdata[3:0] & bcal_pkg::MOD_WMASK;
			if (sel_ovw)
				ovw_reg <= pwdata[NCH-1:0];
			if (sel_mask)
				mask_reg <= pwdata[NI-1:0];
		end
	end

	// Edge detection on capture inputs, per-channel edge select
	logic [NCH-1:0] edge_evt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cap_prev_reg <= '0;
		else
			cap_prev_reg <= cap_in;
	end

	// Capture channels and accumulators
	logic [NCH-1:0] cap_rd;
	logic [NCH-1:0] hold_rd;
	logic [NCH-1:0] captured;
	logic [NCH-1:0] acc_ovf;
	logic [NCH-1:0][15:0] cap_val;
	logic [NCH-1:0][15:0] hold_val;
	logic [NCH-1:0][7:0] acc_val;
	logic [NCH-1:0][7:0] acc_hold_val;

	genvar i;
	generate
		for (i = 0; i < NCH; i = i + 1) begin : g_ch
			bcal_pkg::bcal_chan_ctl_type cctl;
			bcal_pkg::bcal_acc_ctl_type actl;
			wire [1:0] esel = sys_reg[bcal_pkg::SYS_EDGE + 2*i +: 2];
			wire rise = cap_in[i] & ~cap_prev_reg[i];
			wire fall = ~cap_in[i] & cap_prev_reg[i];
			wire pair_casc = casc[i/2];
			wire partner_rd = pair_casc & hold_rd[i ^ 1];

			assign edge_evt[i] = (esel[0] & rise) | (esel[1] & fall);
			assign cap_rd[i] = rd & sel_cap & (idx == 2'(i));
			assign hold_rd[i] = rd & sel_hold & (idx == 2'(i));

			assign cctl.latch_mode = latch_mode;
			assign cctl.no_overwrite_bit = ovw_reg[i];
			assign cctl.latch_evt = latch_evt;
			assign cctl.cap_rd = cap_rd[i];
			assign cctl.hold_rd = hold_rd[i];

			// Odd accumulator counts the carry of its partner when cascaded
			if (i % 2 == 1) begin : g_hi
				assign actl.inc = pair_casc ? acc_ovf[i-1] : edge_evt[i];
			end else begin : g_lo
				assign actl.inc = edge_evt[i];
			end
			assign actl.sat = sat_en & ~pair_casc;
			assign actl.latch_evt = latch_evt
				| (~latch_mode & (hold_rd[i] | partner_rd));

			bcal_chan #(.W(16)) u_chan (
				.pclk(pclk),
				.presetn(presetn),
				.edge_evt(edge_evt[i]),
				.timer(timer_reg),
				.ctl(cctl),
				.cap_reg(cap_val[i]),
				.hold_reg(hold_val[i]),
				.cap_full_reg(),
				.hold_full_reg(),
				.captured(captured[i])
			);

			bcal_acc #(.W(8)) u_acc (
				.pclk(pclk),
				.presetn(presetn),
				.ctl(actl),
				.cnt_reg(acc_val[i]),
				.hold_reg(acc_hold_val[i]),
				.ovf(acc_ovf[i])
			);
		end
	endgenerate

	// Event sources for the status register
	logic [NI-1:0] st_set;

	assign st_set[bcal_pkg::ST_CH +: 4] = captured;
	assign st_set[bcal_pkg::ST_CH + 4 +: 4] = ext_ch_evt;
	assign st_set[bcal_pkg::ST_MOD] = mod_zero_hit;
	assign st_set[bcal_pkg::ST_PBOV] = acc_ovf[1];
	assign st_set[bcal_pkg::ST_PAIN] = edge_evt[3];
	assign st_set[bcal_pkg::ST_PAOV] = acc_ovf[3];
	assign st_set[bcal_pkg::ST_TOV] = timer_ovf;

	// Sticky flags, write one to clear, a new event wins over the clear
	wire [NI-1:0] st_clr = (wr & sel_status) ? pwdata[NI-1:0] : '0;
	assign status_next = (status_reg & ~st_clr) | st_set;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= '0;
			irq_reg <= '0;
		end else begin
			status_reg <= status_next;
			irq_reg <= status_reg & mask_reg;
		end
	end

	// Interrupt outputs, one per source plus a combined line
	assign irq_ch = irq_reg[bcal_pkg::ST_CH +: 8];
	assign irq_mod = irq_reg[bcal_pkg::ST_MOD];
	assign irq_pbov = irq_reg[bcal_pkg::ST_PBOV];
	assign irq_pain = irq_reg[bcal_pkg::ST_PAIN];
	assign irq_paov = irq_reg[bcal_pkg::ST_PAOV];
	assign irq_tov = irq_reg[bcal_pkg::ST_TOV];

	logic irq_any_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_any_reg <= 1'b0;
		else
			irq_any_reg <= |(status_reg & mask_reg);
	end

	assign irq_any = irq_any_reg;

	// Read data selection
	wire [31:0] rd_mux =
		sel_sys ? {16'h0000, sys_reg} :
		sel_mod_ctl ? {28'h0000000, mod_ctl_reg} :
		sel_ovw ? {{(32-NCH){1'b0}}, ovw_reg} :
		sel_mod_cnt ? {16'h0000, mod_cnt_reg} :
		sel_status ? {{(32-NI){1'b0}}, status_reg} :
		sel_mask ? {{(32-NI){1'b0}}, mask_reg} :
		sel_timer ? {16'h0000, timer_reg} :
		sel_cap ? {16'h0000, cap_val[idx]} :
		sel_hold ? {16'h0000, hold_val[idx]} :
		sel_acc ? {24'h000000, acc_val[idx]} :
		sel_acc_hold ? {24'h000000, acc_hold_val[idx]} :
		32'h00000000;

	// APB slave: one wait state, data and error registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= acc_ph & ~pready_reg;
			if (acc_ph && !pready_reg) begin
				prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
				pslverr_reg <= ~mapped;
			end else begin
				prdata_reg <= 32'h00000000;
				pslverr_reg <= 1'b0;
			end
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

endmodule : bcal_top

`default_nettype wire

// File: verification/bcal_irq_host.sv
`timescale 1ns/1ps
`default_nettype none

module bcal_irq_host (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic irq_any,
	output logic [7:0] req_cnt
);
	logic seen_reg;

	// Counts each new request raised toward the host
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_reg <= 1'b0;
			req_cnt <= 8'h00;
		end else begin
			seen_reg <= irq_any;
			if (irq_any && !seen_reg) begin
				req_cnt <= req_cnt + 8'h01;
			end
		end
	end
endmodule : bcal_irq_host

`default_nettype wire

// File: verification/bcal_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module bcal_top_asserts #(
	parameter int TICK_DIV = 1,
	parameter int NCH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NCH-1:0] cap_in,
	input wire logic [3:0] ext_ch_evt,
	input wire logic [7:0] irq_ch,
	input wire logic irq_mod,
	input wire logic irq_pbov,
	input wire logic irq_pain,
	input wire logic irq_paov,
	input wire logic irq_tov,
	input wire logic irq_any
);
	logic wr_done;

	// Completed write at this edge
	assign wr_done = psel & penable & pready & pwrite;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	ready_wait_a: assert property (psel && penable && !$past(penable) |=> pready)
		else $error("pready late");
	ready_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
		else $error("pready not a pulse");
	err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("pslverr out of place");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero");
	irq_any_or_a: assert property (irq_any == |{irq_ch, irq_mod, irq_pbov, irq_pain,
		irq_paov, irq_tov}) else $error("irq_any mismatch");
	irq_fall_a: assert property ($fell(irq_any) |-> $past(wr_done) ||
		$past(wr_done, 2) || $past(wr_done, 3)) else $error("irq dropped unasked");
	irq_hold_a: assert property ($rose(irq_any) && !$past(wr_done) |=> irq_any)
		else $error("irq not held");
	chan_rise_a: assert property ($rose(irq_ch[4]) |-> $past(ext_ch_evt[0], 2) ||
		$past(ext_ch_evt[0], 3) || $past(wr_done, 2) || $past(wr_done, 3))
		else $error("channel irq without cause");
endmodule : bcal_top_asserts

bind bcal_top bcal_top_asserts #(.TICK_DIV(TICK_DIV), .NCH(NCH)) chk_u (.pclk(pclk),
	.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_in(cap_in),
	.ext_ch_evt(ext_ch_evt), .irq_ch(irq_ch), .irq_mod(irq_mod), .irq_pbov(irq_pbov),
	.irq_pain(irq_pain), .irq_paov(irq_paov), .irq_tov(irq_tov), .irq_any(irq_any));

`default_nettype wire

// File: verification/test_buffered_capture_accumulator_latch.sv
`timescale 1ns/1ps
`default_nettype none

module test_buffered_capture_accumulator_latch;
	localparam logic [7:0] SYS = bcal_pkg::OFS_SYS, CTL = bcal_pkg::OFS_MOD_CTL;
	localparam logic [7:0] OVW = bcal_pkg::OFS_OVW, CNT = bcal_pkg::OFS_MOD_CNT;
	localparam logic [7:0] STA = bcal_pkg::OFS_STATUS, MSK = bcal_pkg::OFS_MASK;
	localparam logic [7:0] CAP = bcal_pkg::OFS_CAP, HLD = bcal_pkg::OFS_HOLD;
	localparam logic [7:0] ACC = bcal_pkg::OFS_ACC, AHL = bcal_pkg::OFS_ACC_HOLD;
	logic pclk, pready, pslverr, irq_mod, irq_pbov, irq_pain, irq_paov, irq_tov, irq_any, e;
	logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] cap_in = 4'h0, ext_ch_evt = 4'h0;
	logic [7:0] irq_ch, req_cnt;
	logic [31:0] prdata, q, t1, t2;
	int errors = 0, compares = 0;

	bcal_top #(.TICK_DIV(1), .NCH(4)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cap_in(cap_in), .ext_ch_evt(ext_ch_evt),
		.irq_ch(irq_ch), .irq_mod(irq_mod), .irq_pbov(irq_pbov), .irq_pain(irq_pain),
		.irq_paov(irq_paov), .irq_tov(irq_tov), .irq_any(irq_any));
	bcal_irq_host host_u (.pclk(pclk), .presetn(presetn), .irq_any(irq_any),
		.req_cnt(req_cnt));

	// Clock, 5 ns period
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic close_out();
		if (errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out

	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask : rd

	// Runs the timer briefly, then freezes it and reads it
	task automatic snap(output logic [31:0] t);
		wr(CTL, 32'h8);
		repeat (9) @(posedge pclk);
		wr(CTL, 32'h0);
		apb(1'b0, bcal_pkg::OFS_TIMER, 32'h0);
		t = q;
	endtask : snap

	task automatic pulse(input logic [3:0] m, input int n);
		repeat (n) begin
			cap_in <= m;
			@(posedge pclk);
			cap_in <= 4'h0;
			@(posedge pclk);
		end
		repeat (3) @(posedge pclk);
	endtask : pulse

	// Main sequence
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(SYS, 32'h0);
		rd(CNT, 32'h0000FFFF);
		apb(1'b0, 8'hFC, 32'h0);
		chk({q[30:0], e}, 32'h1);
		wr(MSK, 32'h1FFF);
		wr(SYS, 32'h5503);
		ext_ch_evt <= 4'h1;
		@(posedge pclk);
		ext_ch_evt <= 4'h0;
		snap(t1);
		pulse(4'h1, 1);
		chk(irq_ch, 8'h11);
		rd(CAP, t1);
		wr(STA, 32'h1FFF);
		repeat (3) @(posedge pclk);
		chk(irq_any, 1'b0);
		wr(CTL, 32'h4);
		rd(HLD, t1);
		rd(AHL, 32'h1);
		rd(ACC, 32'h0);
		snap(t1);
		pulse(4'h1, 1);
		snap(t2);
		pulse(4'h1, 1);
		rd(CAP, t2);
		pulse(4'h1, 1);
		wr(OVW, 32'h1);
		snap(t1);
		pulse(4'h1, 1);
		rd(CAP, t2);
		pulse(4'h1, 1);
		rd(CAP, t1);
		pulse(4'h1, 1);
		wr(CNT, 32'h0);
		rd(HLD, t1);
		wr(OVW, 32'h0);
		wr(SYS, 32'h5502);
		snap(t1);
		pulse(4'h1, 1);
		snap(t2);
		pulse(4'h1, 1);
		rd(HLD, t1);
		rd(CAP, t2);
		rd(AHL, 32'h2);
		rd(ACC, 32'h0);
		wr(SYS, 32'h5506);
		wr(STA, 32'h1FFF);
		pulse(4'hA, 257);
		rd(ACC + 8'h04, 32'hFF);
		rd(ACC + 8'h0C, 32'hFF);
		rd(STA, 32'h0E0A);
		chk({irq_pbov, irq_pain, irq_paov}, 3'h7);
		wr(SYS, 32'h550B);
		wr(CTL, 32'h4);
		pulse(4'h1, 300);
		rd(ACC, 32'h2C);
		rd(ACC + 8'h04, 32'h01);
		wr(STA, 32'h1FFF);
		wr(CNT, 32'h4);
		wr(CTL, 32'h3);
		for (int i = 0; i < 100 && irq_mod !== 1'b1; i++) @(posedge pclk);
		chk(irq_mod, 1'b1);
		wr(CTL, 32'h1);
		pulse(4'h1, 3);
		wr(CNT, 32'h3);
		repeat (20) @(posedge pclk);
		rd(CNT, 32'h0);
		rd(AHL, 32'h3);
		pulse(4'h1, 5);
		rd(ACC, 32'h5);
		rd(AHL, 32'h3);
		// Both edges selected on channel 0, latching off
		wr(SYS, 32'h0301);
		pulse(4'h1, 4);
		rd(ACC, 32'h0D);
		// Only the timer overflow left enabled
		wr(MSK, 32'h1000);
		repeat (3) @(posedge pclk);
		chk(irq_any, 1'b0);
		wr(CTL, 32'h8);
		for (int i = 0; i < 70000 && irq_tov !== 1'b1; i++) @(posedge pclk);
		chk(irq_tov, 1'b1);
		chk(req_cnt != 8'h00, 1'b1);
		close_out();
	end

	// Watchdog against a hang
	initial begin
		repeat (100000) @(posedge pclk);
		errors++;
		close_out();
	end
endmodule : test_buffered_capture_accumulator_latch

`default_nettype wire
